// ---- mcsr_consts.vh ----
`ifndef MCSR_CONSTS_VH
`define MCSR_CONSTS_VH
// register word index, byte address = 4 * index
`define MCSR_IDX_W 7
`define MCSR_IDX_IND 7'h00
`define MCSR_IDX_BANK 7'h01
`define MCSR_IDX_PC 7'h02
`define MCSR_IDX_STAT 7'h03
`define MCSR_IDX_PTR 7'h04
`define MCSR_IDX_P5 7'h05
`define MCSR_IDX_P6 7'h06
`define MCSR_IDX_P7 7'h07
`define MCSR_IDX_P8 7'h08
`define MCSR_IDX_TMR 7'h05
`define MCSR_IDX_WAKE 7'h0e
`define MCSR_IDX_IRQF 7'h0f
`define MCSR_IDX_RAM_LO 7'h10
`define MCSR_IDX_CORE_MODE_WORD 7'h40
// general register storage: 16 common plus 2 banks of 32
`define MCSR_RAM_WORDS 80
`define MCSR_RAM_COMMON 7'h10
// bank holding the timer count at index 5
`define MCSR_TMR_BANK 2'h3
// field positions
`define MCSR_CORE_MODE_WORD_EDGE 7
`define MCSR_CORE_MODE_WORD_GIE 6
`define MCSR_CORE_MODE_WORD_TSRC 5
`define MCSR_CORE_MODE_WORD_TEDGE 4
`define MCSR_CORE_MODE_WORD_PRE_ON 3
`define MCSR_ST_T 4
`define MCSR_ST_P 3
`define MCSR_ST_Z 2
`define MCSR_ST_DC 1
`define MCSR_ST_C 0
`define MCSR_P8_FILT 5
`define MCSR_P8_DATA 1
`define MCSR_WK_EX1 7
`define MCSR_WK_P6_ON 4
`define MCSR_WK_CMP_ON 2
`define MCSR_WK_CMP 0
`define MCSR_IF_EX0 2
`define MCSR_IF_P6 1
`define MCSR_IF_TMR 0
// readable bit masks
`define MCSR_P7_MASK 8'h8f
`define MCSR_P8_MASK 8'h22
`define MCSR_PTR_MASK 8'h3f
`define MCSR_BANK_MASK 8'h03
// reset values
`define MCSR_CORE_MODE_WORD_RST 8'h00
`define MCSR_PORT_RST 8'h00
`define MCSR_PC_RST 11'h000
`define MCSR_STAT_RST 5'h18
// core operation codes
`define MCSR_OP_NEXT 4'h0
`define MCSR_OP_JMP 4'h1
`define MCSR_OP_CALL 4'h2
`define MCSR_OP_FAR_JUMP 4'h3
`define MCSR_OP_FAR_SUBROUTINE 4'h4
`define MCSR_OP_RET 4'h5
`define MCSR_OP_IRQ_EXIT_OP 4'h6
`define MCSR_OP_ADDPC 4'h7
`define MCSR_OP_IRQ 4'h8
`define MCSR_OP_ENI 4'h9
`define MCSR_OP_IRQ_DISABLE_OP 4'ha
`define MCSR_OP_SLEEP 4'hb
`define MCSR_OP_WATCHDOG_CLEAR_OP 4'hc
`endif

// ---- mcsr_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcsr_core_model (
  // clock
  input wire logic hclk,
  // operation port
  input wire logic op_ready,
  output logic op_valid,
  output logic [3:0] op_code,
  output logic [10:0] op_target,
  output logic [7:0] op_acc,
  // flag update
  output logic alu_flag_we,
  output logic [7:0] alu_result,
  output logic alu_half_carry,
  output logic alu_carry
);
  initial {op_valid, op_code, op_target, op_acc, alu_flag_we, alu_result, alu_half_carry, alu_carry} = '0;
  task automatic op(input logic [3:0] c, input logic [10:0] t, input logic [7:0] a, input int gap);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    {op_valid, op_code, op_target, op_acc} <= {1'b1, c, t, a};
    do @(posedge hclk); while (op_ready !== 1'b1);
    // released lines carry junk, not the old value
    {op_valid, op_code, op_target, op_acc} <= {1'b0, ~c, ~t, ~a};
  endtask
  task automatic alu(input logic [7:0] r, input logic h, input logic c);
    @(posedge hclk);
    {alu_flag_we, alu_result, alu_half_carry, alu_carry} <= {1'b1, r, h, c};
    @(posedge hclk);
    {alu_flag_we, alu_result, alu_half_carry, alu_carry} <= {1'b0, ~r, ~h, ~c};
  endtask
endmodule
`default_nettype wire

// ---- mcsr_timer.v ----
`timescale 1ns/1ps
`default_nettype none
module mcsr_timer (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // sources
  input wire inst_tick,
  input wire timer_pin,
  // control
  input wire timer_clock_source,
  input wire timer_edge_select,
  input wire timer_prescale_on,
  input wire [2:0] timer_prescale_ratio,
  input wire load,
  input wire [7:0] load_val,
  // state
  output reg [7:0] count_q,
  output reg overflow_q
);
  reg pin_q;
  reg [7:0] pre_q;
  wire rise = timer_pin & ~pin_q;
  wire fall = ~timer_pin & pin_q;
  wire src_ev = timer_clock_source ? (timer_edge_select ? fall : rise) : inst_tick;
  wire [8:0] lim = (9'h002 << timer_prescale_ratio) - 9'h001;
  wire pre_hit = ({1'b0, pre_q} == lim);
  wire tick = src_ev & (~timer_prescale_on | pre_hit);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b0;
      pre_q <= 8'h00;
      count_q <= 8'h00;
      overflow_q <= 1'b0;
    end else begin
      pin_q <= timer_pin;
      overflow_q <= 1'b0;
      if (load) begin
        pre_q <= 8'h00;
        count_q <= load_val;
      end else begin
        if (src_ev & timer_prescale_on) begin
          pre_q <= pre_hit ? 8'h00 : pre_q + 8'h01;
        end
        if (tick) begin
          count_q <= count_q + 8'h01;
          overflow_q <= (count_q == 8'hff);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- mcsr_top.v ----
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"
module mcsr_top #(
  parameter SPW = 3,
  parameter [10:0] IRQ_VECTOR = 11'h008
) (
  // ahb-lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // core operation port
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [10:0] op_target,
  input wire [7:0] op_acc,
  output wire op_ready,
  output wire [10:0] program_counter,
  // alu flag update
  input wire alu_flag_we,
  input wire [7:0] alu_result,
  input wire alu_half_carry,
  input wire alu_carry,
  // watchdog and oscillator
  input wire wdt_timeout,
  input wire low_freq_crystal_mode,
  // pins
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  input wire timer_pin,
  input wire comparator_out,
  input wire [7:0] port5_in,
  input wire [7:0] port6_in,
  input wire [7:0] port7_in,
  input wire [7:0] port8_in,
  output wire [7:0] port5_out,
  output wire [7:0] port6_out,
  output wire [7:0] port7_out,
  output wire [7:0] port8_out,
  // events to the core
  output wire irq_request,
  output reg wake_request
);
  localparam DEPTH = 1 << SPW;
  // bus data-phase tracking
  reg act_q, wr_q, rdy_q;
  reg [6:0] idx_q;
  // registers
  reg [7:0] core_mode_word_q, p5_q, p6_q, p7_q, p8_q;
  reg [1:0] bank_q;
  reg [10:0] pc_q;
  reg [SPW-1:0] sp_q;
  reg [4:0] stat_q;
  reg [5:0] ptr_q;
  reg gie_q, filt_en_q, p6_wake_on_q, cmp_wake_on_q;
  reg ex0_q, ex1_q, p6f_q, tmrf_q, cmpf_q, phase_q, far_q;
  // edge and change tracking
  reg pa_q, pb_q, cmp_q;
  reg [7:0] p6s_q, p6filt_q, p6prev_q, rd_d;
  reg [10:0] stk [0:DEPTH-1];
  reg [7:0] ram [0:`MCSR_RAM_WORDS-1];
  reg [6:0] ram_idx;
  wire [7:0] tmr_cnt;
  wire tmr_ovf;
  assign hresp = 1'b0;
  assign hreadyout = ~(act_q & ~wr_q & ~rdy_q);
  wire take = hsel & htrans[1] & hready;
  wire wr_go = act_q & wr_q;
  wire [7:0] wd = hwdata[7:0];
  // indirect port resolves to the pointed register
  wire [6:0] ea = (idx_q == `MCSR_IDX_IND) ? {1'b0, ptr_q} : idx_q;
  wire ctl_rng = (ea >= `MCSR_IDX_P5) && (ea < `MCSR_IDX_RAM_LO);
  wire bank0 = (bank_q == 2'h0);
  wire tmr_sel = (bank_q == `MCSR_TMR_BANK) && (ea == `MCSR_IDX_TMR);
  wire ram_sel = (ea >= `MCSR_IDX_RAM_LO) && (ea < `MCSR_IDX_CORE_MODE_WORD);
  wire ctl_ok = ~ctl_rng | bank0;
  function wr_at;
    input [6:0] a;
    begin
      wr_at = wr_go && (ea == a) && ctl_ok;
    end
  endfunction
  always @* begin
    ram_idx = {3'b000, ea[3:0]};
    if (ea[5]) begin
      ram_idx = {1'b0, bank_q[0], ea[4:0]} + `MCSR_RAM_COMMON;
    end
  end
  // instruction cycle timing
  wire op_fire = op_valid & op_ready;
  wire is_far = (op_code == `MCSR_OP_FAR_JUMP) || (op_code == `MCSR_OP_FAR_SUBROUTINE);
  assign op_ready = phase_q & ~far_q;
  assign program_counter = pc_q;
  wire filt_on = filt_en_q & ~low_freq_crystal_mode;
  wire [7:0] p6_eff = filt_on ? p6filt_q : port6_in;
  wire p6_chg = (p6_eff != p6prev_q);
  wire cmp_chg = (comparator_out != cmp_q);
  wire pol = core_mode_word_q[`MCSR_CORE_MODE_WORD_EDGE];
  wire ev_a = pol ? (pa_q & ~ext_irq_pin_a) : (~pa_q & ext_irq_pin_a);
  wire ev_b = pol ? (pb_q & ~ext_irq_pin_b) : (~pb_q & ext_irq_pin_b);
  wire set_p6 = p6_chg & p6_wake_on_q;
  wire set_cmp = cmp_chg & cmp_wake_on_q;
  assign port5_out = p5_q;
  assign port6_out = p6_q;
  assign port7_out = p7_q & `MCSR_P7_MASK;
  assign port8_out = p8_q & `MCSR_P8_MASK;
  assign irq_request = gie_q & (ex0_q | ex1_q | p6f_q | tmrf_q | cmpf_q);
  mcsr_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .inst_tick(phase_q),
    .timer_pin(timer_pin),
    .timer_clock_source(core_mode_word_q[`MCSR_CORE_MODE_WORD_TSRC]),
    .timer_edge_select(core_mode_word_q[`MCSR_CORE_MODE_WORD_TEDGE]),
    .timer_prescale_on(core_mode_word_q[`MCSR_CORE_MODE_WORD_PRE_ON]),
    .timer_prescale_ratio(core_mode_word_q[2:0]),
    .load(wr_go && tmr_sel),
    .load_val(wd),
    .count_q(tmr_cnt),
    .overflow_q(tmr_ovf)
  );
  // bus phases, reads take one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      rdy_q <= 1'b0;
      idx_q <= 7'h00;
      hrdata <= 32'h00000000;
    end else begin
      if (act_q & ~wr_q & ~rdy_q) begin
        rdy_q <= 1'b1;
        hrdata <= {24'h000000, rd_d};
      end else begin
        rdy_q <= 1'b0;
        act_q <= take;
        wr_q <= hwrite;
        if (take) begin
          idx_q <= haddr[8:2];
        end
      end
    end
  end
  always @* begin
    rd_d = 8'h00;
    if (tmr_sel) begin
      rd_d = tmr_cnt;
    end else if (ram_sel) begin
      rd_d = ram[ram_idx];
    end else if (ctl_ok) begin
      case (ea)
        `MCSR_IDX_CORE_MODE_WORD: rd_d = {core_mode_word_q[7], gie_q, core_mode_word_q[5:0]};
        `MCSR_IDX_BANK: rd_d = {6'h00, bank_q};
        `MCSR_IDX_PC: rd_d = pc_q[7:0];
        `MCSR_IDX_STAT: rd_d = {3'b000, stat_q};
        `MCSR_IDX_PTR: rd_d = {2'b00, ptr_q};
        `MCSR_IDX_P5: rd_d = port5_in;
        `MCSR_IDX_P6: rd_d = p6_eff;
        `MCSR_IDX_P7: rd_d = port7_in & `MCSR_P7_MASK;
        `MCSR_IDX_P8: rd_d = {2'b00, filt_en_q, 3'b000, port8_in[1], 1'b0};
        `MCSR_IDX_WAKE: rd_d = {ex1_q, 2'b00, p6_wake_on_q, 1'b0, cmp_wake_on_q, 1'b0, cmpf_q};
        `MCSR_IDX_IRQF: rd_d = {5'h00, ex0_q, p6f_q, tmrf_q};
        default: rd_d = 8'h00;
      endcase
    end
  end
  always @(posedge hclk) begin
    if (wr_go && ram_sel) begin
      ram[ram_idx] <= wd;
    end
  end
  // control and data registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_mode_word_q <= `MCSR_CORE_MODE_WORD_RST;
      bank_q <= 2'h0;
      ptr_q <= 6'h00;
      p5_q <= `MCSR_PORT_RST;
      p6_q <= `MCSR_PORT_RST;
      p7_q <= `MCSR_PORT_RST;
      p8_q <= `MCSR_PORT_RST;
      filt_en_q <= 1'b0;
      p6_wake_on_q <= 1'b0;
      cmp_wake_on_q <= 1'b0;
    end else begin
      if (wr_at(`MCSR_IDX_CORE_MODE_WORD)) begin
        core_mode_word_q <= wd;
      end
      if (wr_at(`MCSR_IDX_BANK)) begin
        bank_q <= wd[1:0];
      end
      if (wr_at(`MCSR_IDX_PTR)) begin
        ptr_q <= wd[5:0];
      end
      if (wr_at(`MCSR_IDX_P5) && !tmr_sel) begin
        p5_q <= wd;
      end
      if (wr_at(`MCSR_IDX_P6)) begin
        p6_q <= wd;
      end
      if (wr_at(`MCSR_IDX_P7)) begin
        p7_q <= wd & `MCSR_P7_MASK;
      end
      if (wr_at(`MCSR_IDX_P8)) begin
        p8_q <= wd & `MCSR_P8_MASK;
        filt_en_q <= wd[`MCSR_P8_FILT];
      end
      if (wr_at(`MCSR_IDX_WAKE)) begin
        p6_wake_on_q <= wd[`MCSR_WK_P6_ON];
        cmp_wake_on_q <= wd[`MCSR_WK_CMP_ON];
      end
    end
  end
  // hardware-set flags, software may only clear; set wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ex0_q <= 1'b0;
      ex1_q <= 1'b0;
      p6f_q <= 1'b0;
      tmrf_q <= 1'b0;
      cmpf_q <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      ex0_q <= ev_a | (ex0_q & ~(wr_at(`MCSR_IDX_IRQF) & ~wd[`MCSR_IF_EX0]));
      p6f_q <= set_p6 | (p6f_q & ~(wr_at(`MCSR_IDX_IRQF) & ~wd[`MCSR_IF_P6]));
      tmrf_q <= tmr_ovf | (tmrf_q & ~(wr_at(`MCSR_IDX_IRQF) & ~wd[`MCSR_IF_TMR]));
      ex1_q <= ev_b | (ex1_q & ~(wr_at(`MCSR_IDX_WAKE) & ~wd[`MCSR_WK_EX1]));
      cmpf_q <= set_cmp | (cmpf_q & ~(wr_at(`MCSR_IDX_WAKE) & ~wd[`MCSR_WK_CMP]));
      wake_request <= set_p6 | set_cmp;
    end
  end
  // pin sampling, glitch filter needs two equal samples
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      cmp_q <= 1'b0;
      p6s_q <= 8'h00;
      p6filt_q <= 8'h00;
      p6prev_q <= 8'h00;
    end else begin
      pa_q <= ext_irq_pin_a;
      pb_q <= ext_irq_pin_b;
      cmp_q <= comparator_out;
      p6s_q <= port6_in;
      if (p6s_q == port6_in) begin
        p6filt_q <= port6_in;
      end
      p6prev_q <= p6_eff;
    end
  end
  // status: T and P read-only, Z/DC/C from alu or software
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= `MCSR_STAT_RST;
    end else begin
      if (alu_flag_we) begin
        stat_q[`MCSR_ST_Z] <= (alu_result == 8'h00);
        stat_q[`MCSR_ST_DC] <= alu_half_carry;
        stat_q[`MCSR_ST_C] <= alu_carry;
      end else if (wr_at(`MCSR_IDX_STAT)) begin
        stat_q[2:0] <= wd[2:0];
      end
      if (wdt_timeout) begin
        stat_q[`MCSR_ST_T] <= 1'b0;
      end else if (op_fire && op_code == `MCSR_OP_SLEEP) begin
        stat_q[`MCSR_ST_T] <= 1'b1;
        stat_q[`MCSR_ST_P] <= 1'b0;
      end else if (op_fire && op_code == `MCSR_OP_WATCHDOG_CLEAR_OP) begin
        stat_q[`MCSR_ST_T] <= 1'b1;
        stat_q[`MCSR_ST_P] <= 1'b1;
      end
    end
  end
  // global enable and instruction cycle phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_q <= 1'b0;
      phase_q <= 1'b0;
      far_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      if (op_fire) begin
        far_q <= is_far;
      end else if (phase_q) begin
        far_q <= 1'b0;
      end
      if (op_fire) begin
        case (op_code)
          `MCSR_OP_ENI: gie_q <= 1'b1;
          `MCSR_OP_IRQ_EXIT_OP: gie_q <= 1'b1;
          `MCSR_OP_IRQ_DISABLE_OP: gie_q <= 1'b0;
          `MCSR_OP_IRQ: gie_q <= 1'b0;
          default: gie_q <= gie_q;
        endcase
      end
    end
  end
  // program counter and stack
  wire [10:0] pc_inc = pc_q + 11'h001;
  wire [SPW-1:0] sp_dn = sp_q - {{(SPW-1){1'b0}}, 1'b1};
  wire push = op_fire && ((op_code == `MCSR_OP_CALL) || (op_code == `MCSR_OP_FAR_SUBROUTINE) ||
              (op_code == `MCSR_OP_IRQ));
  wire [10:0] push_val = (op_code == `MCSR_OP_IRQ) ? pc_q : pc_inc;
  always @(posedge hclk) begin
    if (push) begin
      stk[sp_q] <= push_val;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= `MCSR_PC_RST;
      sp_q <= {SPW{1'b0}};
    end else if (op_fire) begin
      case (op_code)
        `MCSR_OP_JMP: pc_q <= {pc_q[10], op_target[9:0]};
        `MCSR_OP_CALL: begin
          pc_q <= {pc_q[10], op_target[9:0]};
          sp_q <= sp_q + {{(SPW-1){1'b0}}, 1'b1};
        end
        `MCSR_OP_FAR_JUMP: pc_q <= op_target;
        `MCSR_OP_FAR_SUBROUTINE: begin
          pc_q <= op_target;
          sp_q <= sp_q + {{(SPW-1){1'b0}}, 1'b1};
        end
        `MCSR_OP_IRQ: begin
          pc_q <= IRQ_VECTOR;
          sp_q <= sp_q + {{(SPW-1){1'b0}}, 1'b1};
        end
        `MCSR_OP_RET, `MCSR_OP_IRQ_EXIT_OP: begin
          pc_q <= stk[sp_dn];
          sp_q <= sp_dn;
        end
        `MCSR_OP_ADDPC: pc_q <= pc_q + {3'b000, op_acc};
        default: pc_q <= pc_inc;
      endcase
    end else if (wr_at(`MCSR_IDX_PC)) begin
      pc_q <= {pc_q[10:8], wd};
    end
  end
endmodule
`default_nettype wire

// ---- mcsr_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"
module mcsr_top_monitor (
  // bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // core side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [10:0] op_target,
  input wire logic [7:0] op_acc,
  input wire logic op_ready,
  input wire logic [10:0] program_counter,
  input wire logic irq_request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = op_valid && op_ready;
  wire far = tk && (op_code == `MCSR_OP_FAR_JUMP || op_code == `MCSR_OP_FAR_SUBROUTINE);
  wire pc_hi = program_counter[10];
  wire [2:0] pc_top = program_counter[10:8];
  wire [9:0] tgt_lo = op_target[9:0];
  wire [7:0] wd_lo = hwdata[7:0];
  wire pc_wr = hsel && htrans[1] && hready && hwrite && haddr[8:2] == `MCSR_IDX_PC;
  property p_pc_reset;
    $rose(hresetn) |-> program_counter == 11'h000;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");
  property p_near;
    tk && (op_code == `MCSR_OP_JMP || op_code == `MCSR_OP_CALL) |=> program_counter == {$past(pc_hi), $past(tgt_lo)};
  endproperty
  a_near: assert property (p_near) else $error("in-page target wrong");
  property p_far;
    far |=> program_counter == $past(op_target);
  endproperty
  a_far: assert property (p_far) else $error("far target wrong");
  property p_far_slow;
    far |=> !op_ready [*3] ##1 op_ready;
  endproperty
  a_far_slow: assert property (p_far_slow) else $error("far op cycle count wrong");
  property p_near_fast;
    tk && !far |=> !op_ready ##1 op_ready;
  endproperty
  a_near_fast: assert property (p_near_fast) else $error("op cycle count wrong");
  property p_addpc;
    tk && op_code == `MCSR_OP_ADDPC |=> program_counter == $past(program_counter) + {3'h0, $past(op_acc)};
  endproperty
  a_addpc: assert property (p_addpc) else $error("pc add wrong");
  property p_pc_write;
    pc_wr ##1 !tk |=> program_counter == {$past(pc_top), $past(wd_lo)};
  endproperty
  a_pc_write: assert property (p_pc_write) else $error("pc low byte write wrong");
  property p_irq_off;
    tk && op_code == `MCSR_OP_IRQ |=> !irq_request;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("enable not cleared on irq entry");
endmodule
`default_nettype wire

// ---- mcsr_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_consts.vh"
module mcsr_top_test;
  localparam logic [10:0] VEC = 11'h008;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, op_valid, op_ready, wdt_timeout;
  logic alu_flag_we, alu_half_carry, alu_carry, low_freq_crystal_mode, ext_irq_pin_a, ext_irq_pin_b;
  logic timer_pin, comparator_out, irq_request, wake_request;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] op_code;
  logic [10:0] op_target, program_counter;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0] op_acc, alu_result, t0, port5_in, port6_in, port7_in, port8_in;
  logic [7:0] port5_out, port6_out, port7_out, port8_out;
  int bad_count, checks, wake_count;
  logic [3:0] oc [12] = '{`MCSR_OP_NEXT, `MCSR_OP_JMP, `MCSR_OP_FAR_JUMP, `MCSR_OP_CALL, `MCSR_OP_FAR_SUBROUTINE,
    `MCSR_OP_IRQ, `MCSR_OP_IRQ_EXIT_OP, `MCSR_OP_RET, `MCSR_OP_RET, `MCSR_OP_ADDPC, `MCSR_OP_ENI, `MCSR_OP_IRQ_DISABLE_OP};
  logic [10:0] tg [12] = '{11'h0, 11'h7ff, 11'h5f0, 11'h005, 11'h010, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0};
  logic [10:0] ex [12] = '{11'h001, 11'h3ff, 11'h5f0, 11'h405, 11'h010, VEC, 11'h010, 11'h406, 11'h5f1, 11'h611,
    11'h612, 11'h613};
  assign hready = hreadyout;
  mcsr_top #(.SPW(3), .IRQ_VECTOR(VEC)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .op_valid, .op_code, .op_target, .op_acc, .op_ready, .program_counter,
    .alu_flag_we, .alu_result, .alu_half_carry, .alu_carry, .wdt_timeout, .low_freq_crystal_mode, .ext_irq_pin_a,
    .ext_irq_pin_b, .timer_pin, .comparator_out, .port5_in, .port6_in, .port7_in, .port8_in, .port5_out,
    .port6_out, .port7_out, .port8_out, .irq_request, .wake_request);
  mcsr_core_model u_core (.hclk, .op_ready, .op_valid, .op_code, .op_target, .op_acc, .alu_flag_we, .alu_result,
    .alu_half_carry, .alu_carry);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (wake_request === 1'b1) wake_count++;
  end
  task automatic complete_run;
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'b10, w, 3'b010, 23'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rdv, {24'h0, e});
  endtask
  // one falling and one rising edge per pulse
  task automatic tpulse(input int n);
    repeat (n) begin
      @(posedge hclk);
      timer_pin <= ~timer_pin;
      wt(3);
      timer_pin <= ~timer_pin;
      wt(3);
    end
  endtask
  initial begin
    #(60000 * 50);
    bad_count++;
    complete_run;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, wdt_timeout, low_freq_crystal_mode} = '0;
    {ext_irq_pin_a, ext_irq_pin_b, timer_pin, comparator_out, port6_in} = '0;
    {port5_in, port7_in, port8_in} = {8'ha5, 8'hff, 8'hff};
    wt(16);
    hresetn <= 1'b1;
    rd(`MCSR_IDX_STAT, 8'h18);
    rd(`MCSR_IDX_PC, 8'h00);
    rd(`MCSR_IDX_P8, 8'h02);
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'h20);
    wr(`MCSR_IDX_BANK, 8'hff);
    rd(`MCSR_IDX_BANK, 8'h03);
    wr(`MCSR_IDX_PTR, 8'hff);
    rd(`MCSR_IDX_PTR, 8'h3f);
    wr(`MCSR_IDX_PTR, 8'h12);
    wr(`MCSR_IDX_IND, 8'h5a);
    rd(7'h12, 8'h5a);
    wr(7'h13, 8'ha5);
    wr(`MCSR_IDX_PTR, 8'h13);
    rd(`MCSR_IDX_IND, 8'ha5);
    wr(7'h20, 8'h11);
    wr(`MCSR_IDX_BANK, 8'h00);
    wr(7'h20, 8'h22);
    wr(`MCSR_IDX_BANK, 8'h01);
    rd(7'h20, 8'h11);
    rd(`MCSR_IDX_P5, 8'h00);
    wr(`MCSR_IDX_BANK, 8'h00);
    rd(`MCSR_IDX_P5, 8'ha5);
    rd(`MCSR_IDX_P7, 8'h8f);
    wr(`MCSR_IDX_P8, 8'h20);
    #1 chk({24'h0, port8_out}, 32'h20);
    rd(`MCSR_IDX_P8, 8'h22);
    wr(`MCSR_IDX_P5, 8'h3c);
    #1 chk({24'h0, port5_out}, 32'h3c);
    wr(`MCSR_IDX_P6, 8'h5a);
    #1 chk({24'h0, port6_out}, 32'h5a);
    wr(`MCSR_IDX_P7, 8'hff);
    #1 chk({24'h0, port7_out}, 32'h8f);
    chk({31'h0, hresp}, 32'h0);
    wr(`MCSR_IDX_STAT, 8'he7);
    rd(`MCSR_IDX_STAT, 8'h1f);
    for (int i = 0; i < 12; i++) begin
      u_core.op(oc[i], tg[i], 8'h20, i % 3);
      #1 chk({21'h0, program_counter}, {21'h0, ex[i]});
    end
    wr(`MCSR_IDX_PC, 8'hab);
    #1 chk({21'h0, program_counter}, 32'h6ab);
    u_core.alu(8'h00, 1'b0, 1'b1);
    rd(`MCSR_IDX_STAT, 8'h1d);
    u_core.alu(8'h80, 1'b1, 1'b0);
    rd(`MCSR_IDX_STAT, 8'h1a);
    u_core.op(`MCSR_OP_SLEEP, 11'h0, 8'h0, 0);
    rd(`MCSR_IDX_STAT, 8'h12);
    @(posedge hclk) wdt_timeout <= 1'b1;
    @(posedge hclk) wdt_timeout <= 1'b0;
    rd(`MCSR_IDX_STAT, 8'h02);
    u_core.op(`MCSR_OP_WATCHDOG_CLEAR_OP, 11'h0, 8'h0, 1);
    rd(`MCSR_IDX_STAT, 8'h1a);
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'ha0);
    wr(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) ext_irq_pin_a <= 1'b1;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) ext_irq_pin_a <= 1'b0;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h04);
    chk({31'h0, irq_request}, 32'h0);
    u_core.op(`MCSR_OP_ENI, 11'h0, 8'h0, 0);
    #1 chk({31'h0, irq_request}, 32'h1);
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'ha0);
    rd(`MCSR_IDX_CORE_MODE_WORD, 8'he0);
    wr(`MCSR_IDX_IRQF, 8'h03);
    rd(`MCSR_IDX_IRQF, 8'h00);
    wr(`MCSR_IDX_IRQF, 8'h07);
    rd(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) ext_irq_pin_b <= 1'b1;
    wt(6);
    @(posedge hclk) ext_irq_pin_b <= 1'b0;
    wt(6);
    rd(`MCSR_IDX_WAKE, 8'h80);
    wr(`MCSR_IDX_WAKE, 8'h00);
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'h20);
    @(posedge hclk) ext_irq_pin_a <= 1'b1;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h04);
    u_core.op(`MCSR_OP_IRQ, 11'h0, 8'h0, 0);
    #1 chk({31'h0, irq_request}, 32'h0);
    wr(`MCSR_IDX_IRQF, 8'h00);
    rd(`MCSR_IDX_CORE_MODE_WORD, 8'h20);
    wake_count = 0;
    @(posedge hclk) port6_in <= 8'h01;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) comparator_out <= 1'b1;
    wt(6);
    rd(`MCSR_IDX_WAKE, 8'h00);
    wr(`MCSR_IDX_WAKE, 8'h14);
    @(posedge hclk) port6_in <= 8'h00;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h02);
    @(posedge hclk) comparator_out <= 1'b0;
    wt(6);
    rd(`MCSR_IDX_WAKE, 8'h15);
    chk(wake_count, 32'd2);
    wr(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) port6_in <= 8'h80;
    @(posedge hclk) port6_in <= 8'h00;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h00);
    @(posedge hclk) low_freq_crystal_mode <= 1'b1;
    @(posedge hclk) port6_in <= 8'h80;
    @(posedge hclk) port6_in <= 8'h00;
    wt(6);
    rd(`MCSR_IDX_IRQF, 8'h02);
    wr(`MCSR_IDX_BANK, 8'h03);
    wr(`MCSR_IDX_TMR, 8'hfe);
    @(posedge hclk) timer_pin <= 1'b1;
    wt(6);
    rd(`MCSR_IDX_TMR, 8'hff);
    @(posedge hclk) timer_pin <= 1'b0;
    wt(6);
    rd(`MCSR_IDX_TMR, 8'hff);
    @(posedge hclk) timer_pin <= 1'b1;
    wt(6);
    rd(`MCSR_IDX_TMR, 8'h00);
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'h30);
    tpulse(3);
    rd(`MCSR_IDX_TMR, 8'h03);
    // each timer count write clears the prescaler phase before the next ratio
    for (int c = 0; c < 8; c++) begin
      wr(`MCSR_IDX_CORE_MODE_WORD, 8'h38 | 8'(c));
      wr(`MCSR_IDX_TMR, 8'h00);
      tpulse(4 << c);
      rd(`MCSR_IDX_TMR, 8'h02);
    end
    wr(`MCSR_IDX_CORE_MODE_WORD, 8'h00);
    bus(1'b0, `MCSR_IDX_TMR, 8'h00);
    t0 = rdv[7:0];
    wt(64);
    bus(1'b0, `MCSR_IDX_TMR, 8'h00);
    t0 = rdv[7:0] - t0;
    chk({24'h0, t0}, 32'd34);
    wr(`MCSR_IDX_BANK, 8'h00);
    rd(`MCSR_IDX_IRQF, 8'h03);
    complete_run;
  end
endmodule
bind mcsr_top mcsr_top_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .op_valid, .op_code, .op_target, .op_acc, .op_ready, .program_counter, .irq_request);
`default_nettype wire
